// file: verilog/spcs_serial_port.sv
// Serial port control/status block with its transmitter and receiver.
// Assumes an APB master on pclk and an asynchronous serial line partner.
// Contract
// - In modes 2 and 3 bit 3 is sent as ninth data bit; modes 0 and 1 ignore it.
// - In mode 1 with multiprocessor off the received stop bit lands in bit 2.
// - In modes 2 and 3 the ninth received bit is captured into bit 2.
// - Bit 1 sets after the last data bit is sent and holds until software clears it.
// - Bit 0 sets once the stop bit is sampled (after the last data bit in mode 0) and only software clears it.
// - The control register sits at 98H, resets to zero, bits ordered as specified.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module spcs_serial_port (
  input  wire logic        pclk,       // System clock
  input  wire logic        presetn,    // Async reset, active low
  input  wire logic        pce,        // Clock enable, freezes all state
  input  wire logic        psel,       // APB select
  input  wire logic        penable,    // APB enable
  input  wire logic        pwrite,     // APB direction
  input  wire logic [7:0]  paddr,      // APB byte address
  input  wire logic [31:0] pwdata,     // APB write data
  output logic      [31:0] prdata,     // APB read data
  output logic             pready,     // APB ready
  output logic             pslverr,    // APB error on unmapped address
  output logic             irq,        // Level interrupt
  input  wire logic        ser_rx_i,   // Receive pin level
  output logic             ser_rx_o,   // Mode 0 data out on receive pin
  output logic             ser_rx_oe,  // Mode 0 data drive enable
  output logic             ser_tx_o    // Transmit line or mode 0 shift clock
);
  import spcs_pkg::*;

  logic [7:0]     scs_q, scs_d;
  logic           fe_q, fe_d, fe_sel_q, fe_sel_d;
  logic [15:0]    baud_q, baud_d;
  logic [3:0]     mask_q, mask_d, stat_q, stat_d;
  logic [7:0]     rxbuf_q, rxbuf_d;
  logic [31:0]    prdata_q, prdata_d;
  logic           pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
  spcs_tx_state_t tx_st_q, tx_st_d;
  logic [10:0]    tx_sh_q, tx_sh_d;
  logic [3:0]     tx_cnt_q, tx_cnt_d;
  logic [16:0]    tx_tim_q, tx_tim_d;
  spcs_rx_state_t rx_st_q, rx_st_d;
  logic [9:0]     rx_sh_q, rx_sh_d;
  logic [3:0]     rx_cnt_q, rx_cnt_d;
  logic [16:0]    rx_tim_q, rx_tim_d;
  logic [2:0]     sync_q;
  logic           rx_f_q, rx_f_d;
  logic           ser_tx_q, ser_tx_d, ser_rx_o_q, ser_rx_o_d, ser_rx_oe_q, ser_rx_oe_d;
  logic [1:0]     mode;
  logic [16:0]    period;
  logic           wr, rd, tx_start;
  logic           tx_done_ev, tx_clk_low, rx_ok_ev, ovr_ev, fe_ev, rx_clk_low;
  logic [9:0]     rx_nsh;
  logic [7:0]     rx_data;
  logic           rx_nb, rx_stop;

  // Mode decode shared by both engines
  assign mode   = {scs_q[SPCS_MODE_LOW_BIT], scs_q[SPCS_MODE_HIGH_BIT]};
  assign period = spcs_bit_cycles(mode, baud_q);
  // Request taken in the access cycle; ready is only high there
  assign wr       = psel && penable && pready_q && pwrite;
  assign rd       = psel && penable && pready_q && !pwrite;
  assign tx_start = wr && (paddr == SPCS_DATA_OFFSET) && (tx_st_q == SPCS_TX_IDLE);

  // Register file and bus answers
  always_comb
  begin
    scs_d     = scs_q;
    fe_d      = fe_q;
    fe_sel_d  = fe_sel_q;
    baud_d    = baud_q;
    mask_d    = mask_q;
    rxbuf_d   = rxbuf_q;
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    pready_d  = 1'b0;
    // Read data latched in setup so prdata comes from a flop
    if (psel && !penable)
    begin
      pready_d  = 1'b1;
      pslverr_d = 1'b0;
      case (paddr)
        SPCS_SCS_OFFSET:  prdata_d = {24'h000000, fe_sel_q ? fe_q : scs_q[7], scs_q[6:0]};
        SPCS_DATA_OFFSET: prdata_d = {24'h000000, rxbuf_q};
        SPCS_BAUD_OFFSET: prdata_d = {15'h0000, fe_sel_q, baud_q};
        SPCS_STAT_OFFSET: prdata_d = {28'h0000000, stat_q};
        SPCS_MASK_OFFSET: prdata_d = {28'h0000000, mask_q};
        default:
        begin
          prdata_d  = 32'h00000000;
          pslverr_d = 1'b1;
        end
      endcase
    end
    if (wr)
    begin
      case (paddr)
        SPCS_SCS_OFFSET:
        begin
          scs_d[6:0] = pwdata[6:0];
          if (fe_sel_q)
            fe_d = fe_q && pwdata[7];
          else
            scs_d[7] = pwdata[7];
        end
        SPCS_BAUD_OFFSET:
        begin
          baud_d   = pwdata[15:0];
          fe_sel_d = pwdata[SPCS_FE_SEL_BIT];
        end
        SPCS_MASK_OFFSET: mask_d = pwdata[3:0];
        default: ;
      endcase
    end
    // Hardware sets come last so they win over a same-cycle software clear
    if (tx_done_ev)
      scs_d[SPCS_TXD_BIT] = 1'b1;
    if (rx_ok_ev)
    begin
      scs_d[SPCS_RXD_BIT] = 1'b1;
      rxbuf_d             = rx_data;
      if (mode != 2'd0)
        scs_d[SPCS_RB8_BIT] = rx_nb;
    end
    if (fe_ev)
      fe_d = 1'b1;
    // Read clears only the bits the reader actually saw
    stat_d = stat_q;
    if (rd && (paddr == SPCS_STAT_OFFSET))
      stat_d = stat_q & ~prdata_q[3:0];
    stat_d = stat_d | {fe_ev, ovr_ev, rx_ok_ev, tx_done_ev};
    irq_d  = |(stat_d & mask_d);
  end

  // Register file flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scs_q     <= SPCS_SCS_RESET;
      fe_q      <= 1'b0;
      fe_sel_q  <= 1'b0;
      baud_q    <= SPCS_BAUD_RESET;
      mask_q    <= SPCS_MASK_RESET;
      stat_q    <= 4'h0;
      rxbuf_q   <= 8'h00;
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q     <= 1'b0;
    end
    else if (pce)
    begin
      scs_q     <= scs_d;
      fe_q      <= fe_d;
      fe_sel_q  <= fe_sel_d;
      baud_q    <= baud_d;
      mask_q    <= mask_d;
      stat_q    <= stat_d;
      rxbuf_q   <= rxbuf_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q     <= irq_d;
    end
  end

  // Transmitter; a data write while busy is dropped, not queued
  always_comb
  begin
    tx_st_d    = tx_st_q;
    tx_sh_d    = tx_sh_q;
    tx_cnt_d   = tx_cnt_q;
    tx_tim_d   = tx_tim_q;
    tx_done_ev = 1'b0;
    case (tx_st_q)
      SPCS_TX_IDLE:
        if (tx_start)
        begin
          case (mode)
            2'd0:    tx_sh_d = {3'b111, pwdata[7:0]};
            2'd1:    tx_sh_d = {2'b11, pwdata[7:0], 1'b0};
            default: tx_sh_d = {1'b1, scs_q[SPCS_TB8_BIT], pwdata[7:0], 1'b0};
          endcase
          tx_cnt_d = spcs_frame_bits(mode);
          tx_tim_d = 17'h00000;
          tx_st_d  = SPCS_TX_RUN;
        end
      SPCS_TX_RUN:
      begin
        tx_tim_d = tx_tim_q + 17'h00001;
        if (tx_tim_q == period - 17'h00001)
        begin
          tx_tim_d = 17'h00000;
          tx_sh_d  = {1'b1, tx_sh_q[10:1]};
          tx_cnt_d = tx_cnt_q - 4'h1;
          // Last data bit done: the stop bit (or nothing, in mode 0) is next
          if (tx_cnt_d == ((mode == 2'd0) ? 4'h0 : 4'h1))
            tx_done_ev = 1'b1;
          if (tx_cnt_d == 4'h0)
            tx_st_d = SPCS_TX_IDLE;
        end
      end
      default: tx_st_d = SPCS_TX_IDLE;
    endcase
    tx_clk_low = (tx_st_q == SPCS_TX_RUN) && (mode == 2'd0) && (tx_tim_q < (period >> 1));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_st_q  <= SPCS_TX_IDLE;
      tx_sh_q  <= 11'h7ff;
      tx_cnt_q <= 4'h0;
      tx_tim_q <= 17'h00000;
    end
    else if (pce)
    begin
      tx_st_q  <= tx_st_d;
      tx_sh_q  <= tx_sh_d;
      tx_cnt_q <= tx_cnt_d;
      tx_tim_q <= tx_tim_d;
    end
  end

  // Receiver; start is rechecked at mid-bit to reject glitches
  always_comb
  begin
    rx_st_d  = rx_st_q;
    rx_sh_d  = rx_sh_q;
    rx_cnt_d = rx_cnt_q;
    rx_tim_d = rx_tim_q + 17'h00001;
    rx_ok_ev = 1'b0;
    ovr_ev   = 1'b0;
    fe_ev    = 1'b0;
    rx_nsh   = {rx_f_q, rx_sh_q[9:1]};
    case (mode)
      2'd0:    {rx_stop, rx_nb, rx_data} = {1'b1, scs_q[SPCS_RB8_BIT], rx_nsh[9:2]};
      2'd1:    {rx_stop, rx_nb, rx_data} = {rx_nsh[9], rx_nsh[9], rx_nsh[8:1]};
      default: {rx_stop, rx_nb, rx_data} = {rx_nsh[9], rx_nsh[8], rx_nsh[7:0]};
    endcase
    case (rx_st_q)
      SPCS_RX_IDLE:
      begin
        rx_tim_d = 17'h00000;
        // Mode 0 reception runs whenever enabled and the last byte was taken
        if (mode == 2'd0 && !scs_q[SPCS_RXD_BIT])
        begin
          rx_st_d  = SPCS_RX_DATA;
          rx_cnt_d = spcs_frame_bits(mode);
        end
        else if (mode != 2'd0 && !rx_f_q)
          rx_st_d = SPCS_RX_START;
      end
      SPCS_RX_START:
        if (rx_tim_q == (period >> 1) - 17'h00001)
        begin
          rx_tim_d = 17'h00000;
          rx_cnt_d = spcs_frame_bits(mode) - 4'h1;
          rx_st_d  = rx_f_q ? SPCS_RX_IDLE : SPCS_RX_DATA;
        end
      SPCS_RX_DATA:
        if (rx_tim_q == period - 17'h00001)
        begin
          rx_tim_d = 17'h00000;
          rx_sh_d  = rx_nsh;
          rx_cnt_d = rx_cnt_q - 4'h1;
          if (rx_cnt_d == 4'h0)
          begin
            rx_st_d = SPCS_RX_IDLE;
            fe_ev   = (mode != 2'd0) && !rx_stop;
            // Multiprocessor filter: good stop in mode 1, address frame in 2/3
            if (!(scs_q[SPCS_MP_BIT] && (mode == 2'd1 ? !rx_stop : (mode[1] && !rx_nb))))
            begin
              ovr_ev   = scs_q[SPCS_RXD_BIT];
              rx_ok_ev = !scs_q[SPCS_RXD_BIT];
            end
          end
        end
      default: rx_st_d = SPCS_RX_IDLE;
    endcase
    // Receiver off aborts any frame in progress
    if (!scs_q[SPCS_REN_BIT])
      rx_st_d = SPCS_RX_IDLE;
    rx_clk_low = (rx_st_q == SPCS_RX_DATA) && (mode == 2'd0) && (rx_tim_q < (period >> 1));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_st_q  <= SPCS_RX_IDLE;
      rx_sh_q  <= 10'h000;
      rx_cnt_q <= 4'h0;
      rx_tim_q <= 17'h00000;
    end
    else if (pce)
    begin
      rx_st_q  <= rx_st_d;
      rx_sh_q  <= rx_sh_d;
      rx_cnt_q <= rx_cnt_d;
      rx_tim_q <= rx_tim_d;
    end
  end

  // Pin side: filtered input, registered outputs
  always_comb
  begin
    rx_f_d      = (sync_q[1] == sync_q[2]) ? sync_q[2] : rx_f_q;
    ser_tx_d    = (mode == 2'd0) ? !(tx_clk_low || rx_clk_low)
                                 : ((tx_st_q == SPCS_TX_RUN) ? tx_sh_q[0] : 1'b1);
    ser_rx_o_d  = tx_sh_q[0];
    ser_rx_oe_d = (mode == 2'd0) && (tx_st_q == SPCS_TX_RUN);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_q      <= 3'b111;
      rx_f_q      <= 1'b1;
      ser_tx_q    <= 1'b1;
      ser_rx_o_q  <= 1'b1;
      ser_rx_oe_q <= 1'b0;
    end
    else if (pce)
    begin
      sync_q      <= {sync_q[1:0], ser_rx_i};
      rx_f_q      <= rx_f_d;
      ser_tx_q    <= ser_tx_d;
      ser_rx_o_q  <= ser_rx_o_d;
      ser_rx_oe_q <= ser_rx_oe_d;
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign irq       = irq_q;
  assign ser_tx_o  = ser_tx_q;
  assign ser_rx_o  = ser_rx_o_q;
  assign ser_rx_oe = ser_rx_oe_q;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ren_gate: assert property (pce && !scs_q[SPCS_REN_BIT] |=> rx_st_q == SPCS_RX_IDLE)
    else $error("receiver active while disabled");
  a_tb8_frame: assert property (pce && tx_start && mode[1] |=> tx_sh_q[9] == $past(scs_q[3]))
    else $error("ninth transmit bit not framed");
  a_rb8_stop: assert property (pce && rx_ok_ev && mode == 2'd1 && !scs_q[5]
                               |=> scs_q[2] == $past(rx_stop))
    else $error("stop bit not captured");
  a_rb8_ninth: assert property (pce && rx_ok_ev && mode[1] |=> scs_q[2] == $past(rx_nsh[8]))
    else $error("ninth receive bit not captured");
  a_txd_sticky: assert property (pce && tx_done_ev ##1 !(wr && paddr == SPCS_SCS_OFFSET)
                                 |=> scs_q[1])
    else $error("transmit done flag lost");
  a_rxd_set: assert property (pce && rx_ok_ev |=> scs_q[0] && rxbuf_q == $past(rx_data))
    else $error("receive done flag or data missing");
  a_scs_write: assert property (pce && wr && paddr == SPCS_SCS_OFFSET && !fe_sel_q
                                && !tx_done_ev && !rx_ok_ev |=> scs_q == $past(pwdata[7:0]))
    else $error("control register write lost");
  a_mode_frame: assert property (pce && tx_start |=> tx_cnt_q == spcs_frame_bits($past(mode)))
    else $error("frame length does not follow mode");
  a_irq_level: assert property (irq |-> $past(|(stat_d & mask_d)))
    else $error("interrupt without unmasked status");

  c_tx_mode2: cover property (tx_start && mode == 2'd2 ##[1:1000] tx_done_ev);
  c_rx_mode1: cover property (rx_ok_ev && mode == 2'd1);
  c_overrun:  cover property (ovr_ev);
endmodule : spcs_serial_port

// file: verilog/spcs_pkg.sv
// Shared constants, types and helpers for the serial port control block.
// Assumes a 250 MHz pclk and an APB master with 32-bit data.
package spcs_pkg;
  // Register byte offsets
  localparam logic [7:0]  SPCS_SCS_OFFSET   = 8'h98;
  localparam logic [7:0]  SPCS_DATA_OFFSET  = 8'h9c;
  localparam logic [7:0]  SPCS_BAUD_OFFSET  = 8'ha0;
  localparam logic [7:0]  SPCS_STAT_OFFSET  = 8'ha4;
  localparam logic [7:0]  SPCS_MASK_OFFSET  = 8'ha8;
  // Control register field positions, plus the FE select bit of the baud register
  localparam int          SPCS_MODE_LOW_BIT  = 7;
  localparam int          SPCS_MODE_HIGH_BIT = 6;
  localparam int          SPCS_MP_BIT        = 5;
  localparam int          SPCS_REN_BIT       = 4;
  localparam int          SPCS_TB8_BIT       = 3;
  localparam int          SPCS_RB8_BIT       = 2;
  localparam int          SPCS_TXD_BIT       = 1;
  localparam int          SPCS_RXD_BIT       = 0;
  localparam int          SPCS_FE_SEL_BIT    = 16;
  // Interrupt status bit positions
  localparam int          SPCS_IRQ_TX  = 0;
  localparam int          SPCS_IRQ_RX  = 1;
  localparam int          SPCS_IRQ_OVR = 2;
  localparam int          SPCS_IRQ_FE  = 3;
  // Values after reset
  localparam logic [7:0]  SPCS_SCS_RESET  = 8'h00;
  localparam logic [15:0] SPCS_BAUD_RESET = 16'h000f;
  localparam logic [3:0]  SPCS_MASK_RESET = 4'h0;
  // Bit periods in pclk cycles for the fixed-rate modes
  localparam logic [16:0] SPCS_MODE0_CYC = 17'h0000c;
  localparam logic [16:0] SPCS_MODE2_CYC = 17'h00040;

  typedef enum logic {SPCS_TX_IDLE, SPCS_TX_RUN} spcs_tx_state_t;
  typedef enum logic [1:0] {SPCS_RX_IDLE, SPCS_RX_START, SPCS_RX_DATA} spcs_rx_state_t;

  // Cycles per serial bit for a given mode
  function automatic logic [16:0] spcs_bit_cycles(input logic [1:0] mode,
                                                  input logic [15:0] div);
    case (mode)
      2'd0:    spcs_bit_cycles = SPCS_MODE0_CYC;
      2'd2:    spcs_bit_cycles = SPCS_MODE2_CYC;
      default: spcs_bit_cycles = {1'b0, div} + 17'h00001;
    endcase
  endfunction : spcs_bit_cycles

  // Bits on the line per frame, start and stop included in modes 1 to 3; mode 0 has neither
  function automatic logic [3:0] spcs_frame_bits(input logic [1:0] mode);
    case (mode)
      2'd0:    spcs_frame_bits = 4'd8;
      2'd1:    spcs_frame_bits = 4'd10;
      default: spcs_frame_bits = 4'd11;
    endcase
  endfunction : spcs_frame_bits
endpackage : spcs_pkg

// file: tb/spcs_peer.sv
// Behavioural remote serial device at the far end of the line.
// Assumes modes 1 to 3, an idle-high line and a bit period in pclk cycles.
`timescale 1ns/1ps
module spcs_peer (
  input  wire logic       pclk,     // System clock
  input  wire logic       line_in,  // Line driven by the block
  output logic            line_out, // Line towards the block
  input  wire logic [7:0] bit_cyc,  // Cycles per bit
  input  wire logic       ninth_on  // Nine data bits per frame
);
  logic [8:0] got_q[$];
  logic [8:0] v;

  initial line_out = 1'b1;

  // Frame catcher, mid-bit sampling; a bad stop bit drops the frame
  always
  begin
    @(negedge line_in);
    repeat (bit_cyc / 2) @(posedge pclk);
    v = '0;
    for (int i = 0; i < (ninth_on ? 9 : 8); i++)
    begin
      repeat (bit_cyc) @(posedge pclk);
      v[i] = line_in;
    end
    repeat (bit_cyc) @(posedge pclk);
    if (line_in === 1'b1)
      got_q.push_back(v);
  end

  // One frame LSB first, then two idle bits so the block sees a clean gap
  task automatic send(input logic [8:0] d, input logic stop);
    @(posedge pclk);
    line_out <= 1'b0;
    repeat (bit_cyc) @(posedge pclk);
    for (int i = 0; i < (ninth_on ? 9 : 8); i++)
    begin
      line_out <= d[i];
      repeat (bit_cyc) @(posedge pclk);
    end
    line_out <= stop;
    repeat (bit_cyc) @(posedge pclk);
    line_out <= 1'b1;
    repeat (2 * bit_cyc) @(posedge pclk);
  endtask : send
endmodule : spcs_peer

// file: tb/tb_top.sv
// Self-checking bench for the serial port control block.
// Assumes spcs_pkg and the peer model are compiled before this file.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
  import spcs_pkg::*;
  localparam logic [15:0] DIV = 16'h0003;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        ser_rx_o;
  logic        ser_rx_oe;
  logic        ser_tx_o;
  logic        peer_out;
  logic        rx_pin;
  logic [7:0]  bit_cyc = 8'h04;
  logic        ninth_on = 1'b0;
  logic [31:0] rdat;
  logic        rerr;
  logic [1:0]  m;
  logic [7:0]  ctl;
  logic [7:0]  db;
  logic        t8;
  logic        ren;
  logic        rb8_m = 1'b0;
  logic [8:0]  v;
  logic [8:0]  got9;
  int          errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int unsigned seed;

  always #2 pclk = ~pclk;

  // Receive pin resolves the mode 0 drive against the peer
  assign rx_pin = ser_rx_oe ? ser_rx_o : peer_out;

  spcs_serial_port u_dut (.pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .ser_rx_i(rx_pin),
    .ser_rx_o(ser_rx_o), .ser_rx_oe(ser_rx_oe), .ser_tx_o(ser_tx_o));

  spcs_peer u_peer (.pclk(pclk), .line_in(ser_tx_o), .line_out(peer_out),
    .bit_cyc(bit_cyc), .ninth_on(ninth_on));

  task automatic results();
    if (errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  // One APB transfer; request held until pready is seen high.
  // Ready and data are read mid-cycle, where they are settled,
  // so the bench never races the edge that launches them.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(negedge pclk);
      ok   = (pready === 1'b1);
      rdat = prdata;
      rerr = pslverr;
      @(posedge pclk);
    end
    while (!ok);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Hang guard, well above the fewer than two thousand cycles the run needs
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      errors++;
      results();
    end
  end

  initial
  begin
    seed = $urandom(32'hbff9);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, SPCS_SCS_OFFSET, 32'h0);
    `CHK("scs reset", 32'h0, rdat)
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped err", 1'b1, rerr)
    apb(1'b1, SPCS_BAUD_OFFSET, {16'h0, DIV});
    // Transmit in modes 1..3 with a random ninth bit
    for (int k = 1; k < 4; k++)
    begin
      m = 2'(k);
      t8 = 1'($urandom);
      db = 8'($urandom);
      bit_cyc = (m == 2'd2) ? SPCS_MODE2_CYC[7:0] : DIV[7:0] + 8'h01;
      ninth_on = m[1];
      ctl = {m, 2'b00, t8, 3'b000};
      apb(1'b1, SPCS_SCS_OFFSET, {24'h0, ctl});
      apb(1'b1, SPCS_DATA_OFFSET, {24'h0, db});
      for (int j = 0; j < 3000 && u_peer.got_q.size() == 0; j++) @(posedge pclk);
      got9 = u_peer.got_q.pop_front();
      `CHK("tx frame", {t8 & m[1], db}, got9)
      // Let the stop bit finish before the next frame is loaded
      repeat (64) @(posedge pclk);
      apb(1'b0, SPCS_SCS_OFFSET, 32'h0);
      `CHK("tx done", {24'h0, ctl | 8'h02}, rdat)
      if (m == 2'd1)
      begin
        `CHK("irq masked", 1'b0, irq)
        apb(1'b1, SPCS_MASK_OFFSET, 32'h3);
        repeat (2) @(posedge pclk);
      end
      `CHK("irq on", 1'b1, irq)
      apb(1'b0, SPCS_STAT_OFFSET, 32'h0);
      `CHK("stat tx", 32'h1, rdat)
      apb(1'b1, SPCS_SCS_OFFSET, {24'h0, ctl});
      apb(1'b0, SPCS_SCS_OFFSET, 32'h0);
      `CHK("tx cleared", {24'h0, ctl}, rdat)
      `CHK("irq off", 1'b0, irq)
    end
    // Receive in modes 1 and 3, receiver off then on
    bit_cyc = DIV[7:0] + 8'h01;
    for (int k = 0; k < 4; k++)
    begin
      m = k[1] ? 2'd3 : 2'd1;
      ren = k[0];
      ninth_on = m[1];
      v = 9'($urandom);
      ctl = {m, 1'b0, ren, 1'b0, rb8_m, 2'b00};
      apb(1'b1, SPCS_SCS_OFFSET, {24'h0, ctl});
      u_peer.send(v, 1'b1);
      if (ren)
        rb8_m = m[1] ? v[8] : 1'b1;
      apb(1'b0, SPCS_SCS_OFFSET, 32'h0);
      `CHK("rx flags", {24'h0, ctl[7:3], rb8_m, 1'b0, ren}, rdat)
      if (ren)
      begin
        apb(1'b0, SPCS_DATA_OFFSET, 32'h0);
        `CHK("rx data", {24'h0, v[7:0]}, rdat)
        apb(1'b0, SPCS_STAT_OFFSET, 32'h0);
        `CHK("stat rx", 32'h2, rdat)
        apb(1'b1, SPCS_SCS_OFFSET, {24'h0, ctl[7:3], rb8_m, 2'b00});
      end
    end
    results();
  end
endmodule : tb_top
